// >>> shared/psrc_pkg.sv
package psrc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 125;
  // Least low time of the warning input, in ns
  localparam int unsigned WARN_MIN_LOW_NS  = 1000;
  localparam int unsigned WARN_MIN_LOW_CYC =
    (WARN_MIN_LOW_NS * CLK_MHZ + 999) / 1000;
  // Longest time allowed for the mirror park, in ns
  localparam int unsigned PARK_MAX_NS      = 4000;
  localparam int unsigned PARK_MAX_CYC     =
    ((PARK_MAX_NS * CLK_MHZ) / 1000 > 0) ?
    (PARK_MAX_NS * CLK_MHZ) / 1000 : 1;
  localparam int unsigned CNT_W            = 10;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [1:0]       SYNC_RST = 2'h0;
  // Controller reset asserted, no park, no event
  localparam logic [2:0]       CTRL_RST = 3'h4;
  localparam logic [CNT_W-1:0] CNT_RST  = 10'h0;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    PSRC_OFF   = 4'h1,
    PSRC_RUN   = 4'h2,
    PSRC_PARK  = 4'h4,
    PSRC_HOLD  = 4'h8
  } psrc_state_e;

  typedef struct packed {
    logic supply_valid_sense;
    logic power_ok_warning;
  } psrc_sense_s;

  typedef struct packed {
    logic ctrl_reset;
    logic park_req;
    logic warn_event;
  } psrc_ctrl_s;

endpackage : psrc_pkg

// >>> verilog/psrc_sync.sv
module psrc_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // Level in and out
  input  wire logic d_i,
  output logic      q_o
);

  logic [1:0] sync_r;

  // ---------------------------------------------------------------
  // Two flop synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sync_r <= psrc_pkg::SYNC_RST;
    end else begin
      sync_r <= {sync_r[0], d_i};
    end
  end

  assign q_o = sync_r[1];

endmodule : psrc_sync

// >>> verilog/psrc_top.sv
module psrc_top (
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 srst_i,
  // Power status inputs
  input  wire logic                 supply_valid_sense_i,
  input  wire logic                 power_ok_warning_i,
  // Mirror park handshake
  input  wire logic                 park_done_i,
  // Outputs
  output logic                      ctrl_reset_o,
  output logic                      park_req_o,
  output logic                      warn_event_o,
  output psrc_pkg::psrc_state_e     state_o
);

  psrc_pkg::psrc_sense_s  sense;
  psrc_pkg::psrc_state_e  state_r;
  psrc_pkg::psrc_state_e  state_nxt;
  psrc_pkg::psrc_ctrl_s   ctrl_r;
  psrc_pkg::psrc_ctrl_s   ctrl_nxt;
  logic [psrc_pkg::CNT_W-1:0] low_cnt_r;
  logic [psrc_pkg::CNT_W-1:0] low_cnt_nxt;
  logic [psrc_pkg::CNT_W-1:0] park_cnt_r;
  logic [psrc_pkg::CNT_W-1:0] park_cnt_nxt;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  psrc_sync u_sync_sv (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (supply_valid_sense_i),
    .q_o    (sense.supply_valid_sense)
  );

  psrc_sync u_sync_pw (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .d_i    (power_ok_warning_i),
    .q_o    (sense.power_ok_warning)
  );

  // ---------------------------------------------------------------
  // Limits
  // ---------------------------------------------------------------
  localparam logic [psrc_pkg::CNT_W-1:0] LOW_LIM =
    psrc_pkg::CNT_W'(psrc_pkg::WARN_MIN_LOW_CYC);
  localparam logic [psrc_pkg::CNT_W-1:0] PARK_LIM =
    psrc_pkg::CNT_W'(psrc_pkg::PARK_MAX_CYC);
  localparam logic [psrc_pkg::CNT_W-1:0] LOW_LAST  = LOW_LIM - 1'b1;
  localparam logic [psrc_pkg::CNT_W-1:0] PARK_LAST = PARK_LIM - 1'b1;

  // ---------------------------------------------------------------
  // Synchronised levels
  // ---------------------------------------------------------------
  wire supplies_ok = sense.supply_valid_sense;
  wire warn_high   = sense.power_ok_warning;

  // ---------------------------------------------------------------
  // Warning low timer
  // ---------------------------------------------------------------
  wire [psrc_pkg::CNT_W-1:0] low_inc = low_cnt_r + 1'b1;
  wire                       low_full = (low_cnt_r == LOW_LIM);
  // Low long enough to count as a real warning
  wire warn_qual = ~warn_high && (low_cnt_r >= LOW_LAST);

  // Count consecutive low cycles; any high restarts it
  assign low_cnt_nxt = warn_high ? '0 :
                       low_full  ? low_cnt_r :
                       low_inc;

  // ---------------------------------------------------------------
  // Park timer
  // ---------------------------------------------------------------
  wire                       in_park   = (state_r == psrc_pkg::PSRC_PARK);
  wire [psrc_pkg::CNT_W-1:0] park_inc  = park_cnt_r + 1'b1;
  wire                       park_full = (park_cnt_r >= PARK_LAST);
  // Done from the mirror side, or give up after the limit
  wire                       park_end  = park_done_i || park_full;

  assign park_cnt_nxt = in_park ? park_inc : '0;

  // ---------------------------------------------------------------
  // Transition conditions
  // ---------------------------------------------------------------
  wire go_run   = supplies_ok && warn_high;
  wire go_off   = ~supplies_ok;
  wire go_park  = warn_qual;
  wire go_hold  = park_end;
  wire go_leave = warn_high;

  // ---------------------------------------------------------------
  // State machine
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      psrc_pkg::PSRC_OFF: begin
        if (go_run) begin
          state_nxt = psrc_pkg::PSRC_RUN;
        end
      end
      psrc_pkg::PSRC_RUN: begin
        if (go_off) begin
          state_nxt = psrc_pkg::PSRC_OFF;
        end else if (go_park) begin
          state_nxt = psrc_pkg::PSRC_PARK;
        end
      end
      psrc_pkg::PSRC_PARK: begin
        if (go_hold) begin
          state_nxt = psrc_pkg::PSRC_HOLD;
        end
      end
      psrc_pkg::PSRC_HOLD: begin
        if (go_leave) begin
          state_nxt = psrc_pkg::PSRC_OFF;
        end
      end
      default: begin
        state_nxt = psrc_pkg::PSRC_OFF;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Output decode
  // ---------------------------------------------------------------
  wire in_run   = (state_r == psrc_pkg::PSRC_RUN);
  wire nxt_run  = (state_nxt == psrc_pkg::PSRC_RUN);
  wire nxt_park = (state_nxt == psrc_pkg::PSRC_PARK);
  // Reset stays off only while running or parking
  wire reset_on = ~nxt_run && ~nxt_park;
  wire park_on  = nxt_park;
  // One pulse as a qualified warning starts the park
  wire warn_hit = in_run && nxt_park;

  assign ctrl_nxt = '{ctrl_reset: reset_on,
                      park_req:   park_on,
                      warn_event: warn_hit};

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= psrc_pkg::PSRC_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Output register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_r <= psrc_pkg::CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Warning low counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      low_cnt_r <= psrc_pkg::CNT_RST;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Park counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      park_cnt_r <= psrc_pkg::CNT_RST;
    end else begin
      park_cnt_r <= park_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Port drive
  // ---------------------------------------------------------------
  assign ctrl_reset_o = ctrl_r.ctrl_reset;
  assign park_req_o   = ctrl_r.park_req;
  assign warn_event_o = ctrl_r.warn_event;
  assign state_o      = state_r;

endmodule : psrc_top

// >>> tb/psrc_top_monitor.sv
module psrc_chk (
  // Clock and reset
  input wire logic                  clk_i,
  input wire logic                  srst_i,
  // Watched ports
  input wire logic                  supply_valid_sense_i,
  input wire logic                  power_ok_warning_i,
  input wire logic                  park_done_i,
  input wire logic                  ctrl_reset_o,
  input wire logic                  park_req_o,
  input wire logic                  warn_event_o,
  input wire psrc_pkg::psrc_state_e state_o
);
  logic [9:0] low_r;
  always_ff @(posedge clk_i) begin
    low_r <= power_ok_warning_i ? 10'h0 : low_r + {9'h0, ~&low_r};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  property p_sup;
    !$past(supply_valid_sense_i, 3) && !park_req_o |-> ctrl_reset_o;
  endproperty
  a_sup: assert property (p_sup)
    else $error("reset off, supply low");
  property p_exit;
    $fell(ctrl_reset_o) |-> $past(power_ok_warning_i, 3);
  endproperty
  a_exit: assert property (p_exit)
    else $error("left reset early");
  property p_park;
    $fell(park_req_o) |-> ctrl_reset_o && !warn_event_o;
  endproperty
  a_park: assert property (p_park)
    else $error("no reset after park");
  property p_glit;
    $rose(park_req_o) |-> low_r >= psrc_pkg::WARN_MIN_LOW_CYC;
  endproperty
  a_glit: assert property (p_glit)
    else $error("short low parked");
  property p_hold;
    state_o == psrc_pkg::PSRC_HOLD && !power_ok_warning_i |-> ##3 ctrl_reset_o;
  endproperty
  a_hold: assert property (p_hold)
    else $error("reset dropped");
  property p_sync;
    $fell(power_ok_warning_i) && !ctrl_reset_o |=> !ctrl_reset_o;
  endproperty
  a_sync: assert property (p_sync)
    else $error("unsynced input");
endmodule : psrc_chk

bind psrc_top psrc_chk u_chk (.clk_i, .srst_i, .supply_valid_sense_i,
  .power_ok_warning_i, .park_done_i, .ctrl_reset_o, .park_req_o,
  .warn_event_o, .state_o);

// >>> tb/psrc_supply_model.sv
module psrc_supply_model #(
  parameter int DLY = 700
) (
  // Control
  input  wire logic clk_i,
  input  wire logic on_i,
  input  wire logic glitch_i,
  // Power status
  output logic      sense_o,
  output logic      warn_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int dly_r;
  initial begin
    sense_o = 1'b0;
    warn_o  = 1'b0;
    dly_r   = 0;
  end
  always @(posedge clk_i) begin
    warn_o  <= on_i & sense_o & ~glitch_i;
    sense_o <= on_i | (sense_o & (dly_r < DLY));
    dly_r   <= warn_o ? 0 : dly_r + 1;
  end
endmodule : psrc_supply_model

// >>> tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, srst_i = 1'b1, on_c = 1'b0, gl_c = 1'b0;
  logic park_done_i = 1'b0;
  logic sense, warn, ctrl_reset_o, park_req_o, warn_event_o;
  psrc_pkg::psrc_state_e state_o;
  int num_errors = 0, samples_checked = 0;
  always #4 clk_i = ~clk_i;
  psrc_supply_model u_sup (.clk_i, .on_i(on_c), .glitch_i(gl_c),
    .sense_o(sense), .warn_o(warn));
  psrc_top u_dut (.clk_i, .srst_i, .supply_valid_sense_i(sense),
    .power_ok_warning_i(warn), .park_done_i, .ctrl_reset_o, .park_req_o,
    .warn_event_o, .state_o);
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic chk_bit(logic got, logic exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %0t bit %b", $time, got);
    end
  endtask : chk_bit
  task automatic chk_st(psrc_pkg::psrc_state_e exp);
    samples_checked++;
    if (state_o !== exp) begin
      num_errors++;
      $display("mismatch %0t state %h", $time, state_o);
    end
  endtask : chk_st
  task automatic wait_st(psrc_pkg::psrc_state_e exp);
    int n;
    n = 0;
    while (state_o !== exp && n < 1000) begin
      @(posedge clk_i) #1;
      n++;
    end
    chk_st(exp);
    if (state_o !== exp) test_done();
  endtask : wait_st
  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i) #1;
    chk_bit(ctrl_reset_o, 1'b1);
    chk_st(psrc_pkg::PSRC_OFF);
    @(posedge clk_i) on_c <= 1'b1;
    wait_st(psrc_pkg::PSRC_RUN);
    chk_bit(ctrl_reset_o, 1'b0);
    @(posedge clk_i) gl_c <= 1'b1;
    repeat (120) @(posedge clk_i);
    gl_c <= 1'b0;
    repeat (20) @(posedge clk_i) #1;
    chk_st(psrc_pkg::PSRC_RUN);
    chk_bit(park_req_o, 1'b0);
    @(posedge clk_i) gl_c <= 1'b1;
    wait_st(psrc_pkg::PSRC_PARK);
    chk_bit(warn_event_o, 1'b1);
    chk_bit(park_req_o, 1'b1);
    chk_bit(ctrl_reset_o, 1'b0);
    @(posedge clk_i) park_done_i <= 1'b1;
    #1 chk_bit(warn_event_o, 1'b0);
    @(posedge clk_i) park_done_i <= 1'b0;
    #1 chk_st(psrc_pkg::PSRC_HOLD);
    chk_bit(park_req_o, 1'b0);
    repeat (200) @(posedge clk_i) #1;
    chk_bit(ctrl_reset_o, 1'b1);
    @(posedge clk_i) gl_c <= 1'b0;
    wait_st(psrc_pkg::PSRC_RUN);
    @(posedge clk_i) on_c <= 1'b0;
    wait_st(psrc_pkg::PSRC_PARK);
    wait_st(psrc_pkg::PSRC_HOLD);
    repeat (700) @(posedge clk_i) #1;
    chk_bit(sense, 1'b0);
    chk_bit(ctrl_reset_o, 1'b1);
    test_done();
  end
endmodule : tb_top
